/* File: include/spr_pkg.sv */
/*
 * Constants, encodings and timing for the speed ramp with bus and current limit.
 * Assumes a single 125 MHz clock domain; speeds in 0.01 Hz, times in 0.1 s,
 * voltages in V, currents in 0.1 A, gain in hundredths.
 */
package spr_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_PERIOD_NS = 1_000_000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DS_PERIOD_NS = 100_000_000;
	localparam int TICKS_PER_DS = DS_PERIOD_NS / TICK_PERIOD_NS;

	localparam int SPD_W = 16;
	localparam int FRAC_W = 16;
	localparam int ACC_W = SPD_W + FRAC_W;
	localparam int TIME_W = 14;
	localparam int DEN_W = 20;
	localparam int VOLT_W = 11;
	localparam int GAIN_W = 10;
	localparam int CUR_W = 11;
	localparam int S_LOG2 = 6;

	localparam logic [TIME_W-1:0] TIME_MIN_DS = 14'h0001;
	localparam logic [TIME_W-1:0] TIME_MAX_DS = 14'h2706;
	localparam logic [TIME_W-1:0] RAMP_DEF_DS = 14'h0064;
	localparam logic [TIME_W-1:0] PROT_DEF_DS = 14'h0032;
	localparam logic S_PROFILE_DEF = 1'h0;
	localparam logic [VOLT_W-1:0] DC_MIN_V = 11'h153;
	localparam logic [VOLT_W-1:0] DC_MAX_V = 11'h4b0;
	localparam logic [VOLT_W-1:0] DC_DEF_V0 = 11'h190;
	localparam logic [VOLT_W-1:0] DC_DEF_V1 = 11'h320;
	localparam logic [VOLT_W-1:0] DC_DEF_V2 = 11'h3e8;
	localparam logic [GAIN_W-1:0] GAIN_MAX = 10'h3e7;
	localparam logic [GAIN_W-1:0] GAIN_DEF = 10'h096;
	localparam logic [CUR_W-1:0] CUR_MAX_DA = 11'h7d0;

	typedef enum logic [2:0] {
		SRC_FIRST, SRC_SECOND, SRC_DIGITAL, SRC_SERIAL, SRC_RSVD, SRC_FIELDBUS, SRC_USER
	} spr_src_e;
	localparam spr_src_e SRC_DEF = SRC_DIGITAL;

	// Bit 0 picks voltage accelerate, bit 1 picks current hold
	typedef enum logic [1:0] {
		LIM_VHOLD_CDEC, LIM_VACC_CDEC, LIM_VHOLD_CHOLD, LIM_VACC_CHOLD
	} spr_lim_e;
	localparam spr_lim_e LIM_DEF = LIM_VHOLD_CDEC;

	typedef enum logic {DV_IDLE, DV_RUN} spr_div_state_e;
endpackage

/* File: design/spr_step_div.sv */
/*
 * Sequential restoring divider that turns full speed and ramp length into a
 * per-tick frequency step. Assumes start only when idle and a non-zero divisor.
 */
`timescale 1ns/1ps
`default_nettype none
module spr_step_div import spr_pkg::*; #(
	parameter int NUM_W = 32,
	parameter int DW = 20
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic start_i,
	input wire logic [NUM_W-1:0] num_i,
	input wire logic [DW-1:0] den_i,
	output logic busy_o,
	output logic done_o,
	output logic [NUM_W-1:0] quot_o
);
	if (NUM_W < 2 || NUM_W > 62 || DW < 1) begin : g_chk
		$error("spr_step_div: unsupported width");
	end

	spr_div_state_e state_ff;
	logic [NUM_W-1:0] q_ff;
	logic [DW:0] r_ff;
	logic [5:0] cnt_ff;
	logic [NUM_W-1:0] quot_ff;
	logic done_ff;
	// Divisor is held from start, as the ramp may change direction mid-division
	logic [DW-1:0] den_ff;
	wire [DW:0] shifted = {r_ff[DW-1:0], q_ff[NUM_W-1]};
	wire [DW+1:0] diff = {1'b0, shifted} - {2'h0, den_ff};
	wire fits = ~diff[DW+1];
	wire last = (cnt_ff == 6'h00);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= DV_IDLE;
			q_ff <= '0;
			r_ff <= '0;
			cnt_ff <= 6'h00;
			quot_ff <= '0;
			done_ff <= 1'h0;
			den_ff <= '0;
		end else begin
			done_ff <= 1'h0;
			case (state_ff)
				DV_IDLE: if (start_i) begin
					q_ff <= num_i;
					r_ff <= '0;
					cnt_ff <= 6'(NUM_W - 1);
					den_ff <= den_i;
					state_ff <= DV_RUN;
				end
				DV_RUN: begin
					r_ff <= fits ? diff[DW:0] : shifted;
					q_ff <= {q_ff[NUM_W-2:0], fits};
					cnt_ff <= cnt_ff - 6'h01;
					if (last) begin
						quot_ff <= {q_ff[NUM_W-2:0], fits};
						done_ff <= 1'h1;
						state_ff <= DV_IDLE;
					end
				end
				default: state_ff <= DV_IDLE;
			endcase
		end
	end

	assign busy_o = (state_ff == DV_RUN);
	assign done_o = done_ff;
	assign quot_o = quot_ff;

	sequence s_div_start;
		start_i && !busy_o;
	endsequence
	a_div_finish: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R22]
		s_div_start |-> ##[1:64] done_o) else $error("divider did not finish");
endmodule // spr_step_div
`default_nettype wire

/* File: design/spr_ramp.sv */
/*
 * Speed ramp generator with DC link overvoltage and output overcurrent limits.
 * Assumes settings and measurements come from logic on clk_i; only the
 * digital ramp-select input is a pin and is synchronised here.
 */
// Operation
// [R1] Three ramps: first, alternate, protection; protection overrides the others
// [R2] First ramp accelerates zero to max speed in accel time, default 10.0 s
// [R3] First ramp decelerates max speed to zero in decel time, default 10.0 s
// [R4] Alternate ramp has its own accel and decel times, default 10.0 s
// [R5] Protection ramp uses one time both ways, default 5.0 s
// [R6] S-profile setting 1 shapes ramps into S curves, 0 keeps linear
// [R7] Source selector: standard, alternate, input, serial, reserved, fieldbus, program
// [R8] Inactive or unassigned source falls back to the standard ramp
// [R9] Status reports whether the alternate ramp is active
// [R10] Limitation acting: protection rate, reference ignored, bounded by speed limits; voltage accelerate still ramps toward the reference
// [R11] DC link limitation beats current limitation when both request
// [R12] Limitation selector: four voltage and current action combinations, default 0
// [R13] Voltage hold freezes a decelerating ramp once bus reaches level
// [R14] Voltage accelerate adds gain times bus error in Hz to output
// [R15] Regulation level 339 to 1200 V, default by supply class
// [R16] Regulator gain 0.00 to 9.99, default 1.50
// [R17] Current hold for selector 2 or 3, decelerate for 0 or 1
// [R18] Configurer disables voltage limitation when rheostatic braking is used
// [R19] Current hold stops speed change while current above max level
// [R20] Current decelerate forces zero speed input while current above level
// [R21] Max current level settable 0.0 to 200.0 A
// [R22] Linear ramps add max speed over ticks per tick, saturating at target
`timescale 1ns/1ps
`default_nettype none
module spr_ramp import spr_pkg::*; #(
	parameter int TICK_CYC = TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic factory_defaults_i,
	input wire logic [SPD_W-1:0] speed_ref_i,
	input wire logic [TIME_W-1:0] accel_time_first_i,
	input wire logic [TIME_W-1:0] decel_time_first_i,
	input wire logic [TIME_W-1:0] accel_time_second_i,
	input wire logic [TIME_W-1:0] decel_time_second_i,
	input wire logic [TIME_W-1:0] protection_ramp_time_i,
	input wire logic s_profile_enable_i,
	input wire logic [2:0] second_ramp_source_sel_i,
	input wire logic digital_input_source_i,
	input wire logic digital_input_assigned_i,
	input wire logic serial_second_ramp_i,
	input wire logic fieldbus_second_ramp_i,
	input wire logic user_prog_second_ramp_i,
	input wire logic protection_ramp_req_i,
	input wire logic [SPD_W-1:0] min_speed_limit_i,
	input wire logic [SPD_W-1:0] max_speed_limit_i,
	input wire logic [CUR_W-1:0] max_current_level_i,
	input wire logic [CUR_W-1:0] motor_current_i,
	input wire logic [1:0] limitation_type_sel_i,
	input wire logic [VOLT_W-1:0] dc_regulation_level_i,
	input wire logic [GAIN_W-1:0] dc_regulator_gain_i,
	input wire logic [VOLT_W-1:0] dc_bus_measured_i,
	input wire logic [1:0] supply_class_sel_i,
	output logic [SPD_W-1:0] freq_cmd_o,
	output logic [SPD_W-1:0] ramp_out_o,
	output logic ramp_tick_o,
	output logic second_ramp_active_o,
	output logic protection_ramp_active_o,
	output logic dc_limit_active_o,
	output logic current_limit_active_o
);
	localparam int CNT_W = $clog2(TICK_CYC);
	if (TICK_CYC < 2 * ACC_W) begin : g_chk
		$error("spr_ramp: tick too short for the step divider");
	end

	function automatic logic [TIME_W-1:0] clamp_time(input logic [TIME_W-1:0] t);
		clamp_time = (t < TIME_MIN_DS) ? TIME_MIN_DS : (t > TIME_MAX_DS) ? TIME_MAX_DS : t;
	endfunction

	function automatic logic [SPD_W-1:0] clamp_spd(input logic [SPD_W-1:0] v,
			input logic [SPD_W-1:0] lo, input logic [SPD_W-1:0] hi);
		clamp_spd = (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction

	function automatic logic src_active(input spr_src_e s, input logic di, input logic di_asg,
			input logic ser, input logic fb, input logic up);
		case (s)
			SRC_FIRST: src_active = 1'h0;
			SRC_SECOND: src_active = 1'h1;
			SRC_DIGITAL: src_active = di & di_asg;
			SRC_SERIAL: src_active = ser;
			SRC_FIELDBUS: src_active = fb;
			SRC_USER: src_active = up;
			default: src_active = 1'h0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Effective settings: factory values or range-limited inputs, except max speed, which is taken as given
	wire dflt = factory_defaults_i;
	wire [TIME_W-1:0] t_acc1 = dflt ? RAMP_DEF_DS : clamp_time(accel_time_first_i); // [R2]
	wire [TIME_W-1:0] t_dec1 = dflt ? RAMP_DEF_DS : clamp_time(decel_time_first_i); // [R3]
	wire [TIME_W-1:0] t_acc2 = dflt ? RAMP_DEF_DS : clamp_time(accel_time_second_i); // [R4]
	wire [TIME_W-1:0] t_dec2 = dflt ? RAMP_DEF_DS : clamp_time(decel_time_second_i); // [R4]
	wire [TIME_W-1:0] t_prot = dflt ? PROT_DEF_DS : clamp_time(protection_ramp_time_i); // [R5]
	wire s_eff = dflt ? S_PROFILE_DEF : s_profile_enable_i; // [R6]
	wire spr_src_e src_eff = dflt ? SRC_DEF : spr_src_e'(second_ramp_source_sel_i); // [R7]
	wire spr_lim_e lim_eff = dflt ? LIM_DEF : spr_lim_e'(limitation_type_sel_i); // [R12]
	// Unlisted supply classes fall back to the lowest level, the safe side
	wire [VOLT_W-1:0] dc_class_def = (supply_class_sel_i == 2'h1) ? DC_DEF_V1 :
		(supply_class_sel_i == 2'h2) ? DC_DEF_V2 : DC_DEF_V0; // [R15]
	wire [VOLT_W-1:0] dc_level = dflt ? dc_class_def :
		(dc_regulation_level_i < DC_MIN_V) ? DC_MIN_V :
		(dc_regulation_level_i > DC_MAX_V) ? DC_MAX_V : dc_regulation_level_i; // [R15]
	wire [GAIN_W-1:0] gain = dflt ? GAIN_DEF :
		(dc_regulator_gain_i > GAIN_MAX) ? GAIN_MAX : dc_regulator_gain_i; // [R16]
	wire [CUR_W-1:0] cur_max = (max_current_level_i > CUR_MAX_DA) ?
		CUR_MAX_DA : max_current_level_i; // [R21]
	wire [SPD_W-1:0] spd_max = max_speed_limit_i;
	wire [SPD_W-1:0] spd_min = (min_speed_limit_i > spd_max) ? spd_max : min_speed_limit_i;

	////////////////////////////////////////////////////////////////////////////////
	// Tick divider and pin synchroniser
	logic [CNT_W-1:0] tick_cnt_ff;
	logic tick_ff;
	logic di_meta_ff;
	logic di_sync_ff;
	wire tick_wrap = (tick_cnt_ff == CNT_W'(TICK_CYC - 1));

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'h0;
			di_meta_ff <= 1'h0;
			di_sync_ff <= 1'h0;
		end else begin
			tick_cnt_ff <= tick_wrap ? '0 : tick_cnt_ff + 1'b1;
			tick_ff <= tick_wrap;
			di_meta_ff <= digital_input_source_i;
			di_sync_ff <= di_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Ramp selection and limitation decisions
	logic [ACC_W-1:0] acc_ff;
	logic [ACC_W-1:0] step_ff;
	logic [S_LOG2:0] s_lvl_ff;
	wire [SPD_W-1:0] ramp_spd = acc_ff[ACC_W-1:FRAC_W];
	wire second_sel = src_active(src_eff, di_sync_ff, digital_input_assigned_i,
		serial_second_ramp_i, fieldbus_second_ramp_i, user_prog_second_ramp_i); // [R7] [R8]
	wire [SPD_W-1:0] ref_lim = clamp_spd(speed_ref_i, spd_min, spd_max);
	wire decel_dir = (ref_lim < ramp_spd);
	wire dc_over = (dc_bus_measured_i >= dc_level);
	wire cur_over = (motor_current_i > cur_max);
	wire v_hold = !lim_eff[0] && dc_over && decel_dir; // [R13]
	wire v_acc = lim_eff[0] && dc_over; // [R14]
	wire dc_act = v_hold | v_acc;
	wire c_hold = lim_eff[1] && cur_over && (ref_lim != ramp_spd) && !dc_act; // [R17] [R19] [R11]
	wire c_dec = !lim_eff[1] && cur_over && !dc_act; // [R17] [R20] [R11]
	wire hold = v_hold | c_hold; // [R13] [R19]
	wire lim_act = dc_act | c_hold | c_dec;
	wire prot_act = protection_ramp_req_i | lim_act; // [R1] [R10]
	wire [SPD_W-1:0] target = c_dec ? clamp_spd('0, spd_min, spd_max) : ref_lim; // [R20] [R10]
	wire up = (target > ramp_spd);
	wire [TIME_W-1:0] t_sel = prot_act ? t_prot : second_sel ? (up ? t_acc2 : t_dec2) :
		(up ? t_acc1 : t_dec1); // [R1] [R2] [R3] [R4] [R5]

	////////////////////////////////////////////////////////////////////////////////
	// Step computation: full speed over ramp length in ticks
	wire [DEN_W-1:0] den = DEN_W'(t_sel) * DEN_W'(TICKS_PER_DS); // [R22]
	wire [ACC_W-1:0] num = {spd_max, {FRAC_W{1'b0}}};
	wire div_done;
	wire [ACC_W-1:0] div_quot;

	// A new ramp time is seen at the tick that starts a division, so it
	// shapes the step one tick late; a cheap divider was worth that lag
	spr_step_div #(.NUM_W(ACC_W), .DW(DEN_W)) u_div (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.start_i(tick_ff),
		.num_i(num),
		.den_i(den),
		.busy_o(),
		.done_o(div_done),
		.quot_o(div_quot)
	);

	// S profile scales the step by a level that grows while moving and shrinks at rest
	wire moving = !hold && (target != ramp_spd);
	wire [ACC_W+S_LOG2:0] s_prod = {{(S_LOG2+1){1'b0}}, step_ff} * {{ACC_W{1'b0}}, s_lvl_ff};
	wire [ACC_W-1:0] step_use = s_eff ? s_prod[ACC_W+S_LOG2-1:S_LOG2] : step_ff; // [R6]
	wire [S_LOG2:0] s_full = {1'b1, {S_LOG2{1'b0}}};
	wire [S_LOG2:0] nxt_s_lvl = !tick_ff ? s_lvl_ff :
		(moving && s_lvl_ff != s_full) ? s_lvl_ff + 1'b1 :
		(!moving && s_lvl_ff != '0) ? s_lvl_ff - 1'b1 : s_lvl_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Ramp integrator with saturation at the target
	wire [ACC_W-1:0] tgt_acc = {target, {FRAC_W{1'b0}}};
	wire [ACC_W:0] sum_up = {1'b0, acc_ff} + {1'b0, step_use};
	wire [ACC_W-1:0] up_next = (sum_up >= {1'b0, tgt_acc}) ? tgt_acc : sum_up[ACC_W-1:0]; // [R22]
	wire [ACC_W-1:0] diff_dn = acc_ff - step_use;
	wire [ACC_W-1:0] dn_next = (acc_ff > step_use && diff_dn > tgt_acc) ? diff_dn : tgt_acc; // [R22]
	wire [ACC_W-1:0] nxt_acc = (!tick_ff || hold) ? acc_ff : up ? up_next : dn_next; // [R13] [R19]

	// Overvoltage correction: positive bus error times gain is in 0.01 Hz already
	wire [VOLT_W-1:0] dc_err = dc_over ? dc_bus_measured_i - dc_level : '0;
	wire [VOLT_W+GAIN_W-1:0] corr = {{GAIN_W{1'b0}}, dc_err} * {{VOLT_W{1'b0}}, gain};
	wire [VOLT_W+GAIN_W:0] f_sum = {{(VOLT_W+GAIN_W+1-SPD_W){1'b0}}, ramp_spd} + {1'b0, corr};
	wire [VOLT_W+GAIN_W:0] max_ext = {{(VOLT_W+GAIN_W+1-SPD_W){1'b0}}, spd_max};
	wire [SPD_W-1:0] nxt_freq = !v_acc ? ramp_spd :
		(f_sum > max_ext) ? spd_max : f_sum[SPD_W-1:0]; // [R14] [R10]

	logic [SPD_W-1:0] freq_ff;
	logic second_ff;
	logic prot_ff;
	logic dc_lim_ff;
	logic cur_lim_ff;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			acc_ff <= '0;
			step_ff <= '0;
			s_lvl_ff <= '0;
			freq_ff <= '0;
		end else begin
			acc_ff <= nxt_acc;
			s_lvl_ff <= nxt_s_lvl;
			if (div_done)
				step_ff <= div_quot;
			if (tick_ff)
				freq_ff <= nxt_freq;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			second_ff <= 1'h0;
			prot_ff <= 1'h0;
			dc_lim_ff <= 1'h0;
			cur_lim_ff <= 1'h0;
		end else begin
			second_ff <= second_sel && !prot_act; // [R9] [R1]
			prot_ff <= prot_act;
			dc_lim_ff <= dc_act;
			cur_lim_ff <= c_hold | c_dec;
		end
	end

	assign freq_cmd_o = freq_ff;
	assign ramp_out_o = ramp_spd;
	assign ramp_tick_o = tick_ff;
	assign second_ramp_active_o = second_ff;
	assign protection_ramp_active_o = prot_ff;
	assign dc_limit_active_o = dc_lim_ff;
	assign current_limit_active_o = cur_lim_ff;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_tick_hold;
		tick_ff && hold;
	endsequence
	sequence s_tick_up;
		tick_ff && !hold && up;
	endsequence
	sequence s_tick_down;
		tick_ff && !hold && !up;
	endsequence

	a_hold_freezes: assert property (s_tick_hold |=> acc_ff == $past(acc_ff)) // [R13]
		else $error("ramp moved while held");
	a_up_saturate: assert property (s_tick_up |=> acc_ff <= $past(tgt_acc) && // [R22]
		acc_ff >= $past(acc_ff)) else $error("ramp overshot target");
	a_dc_wins: assert property (dc_act && cur_over |=> dc_lim_ff && !cur_lim_ff) // [R11]
		else $error("current limit beat bus limit");
	a_vhold_decel: assert property (v_hold |-> decel_dir && !lim_eff[0]) // [R13]
		else $error("voltage hold outside deceleration");
	a_cdec_target: assert property (c_dec |-> target == spd_min && prot_act) // [R20]
		else $error("current decel target wrong");
	a_prot_time: assert property (prot_act |-> t_sel == t_prot) // [R1]
		else $error("protection ramp not selected");
	a_first_forced: assert property ( // [R7]
		(src_eff == SRC_FIRST || src_eff == SRC_RSVD) |=> !second_ff)
		else $error("alternate ramp with standard source");
	a_di_unassigned: assert property (src_eff == SRC_DIGITAL && // [R8]
		!digital_input_assigned_i |=> !second_ff) else $error("alternate ramp without input");
	a_linear_step: assert property (tick_ff && !s_eff |-> step_use == step_ff) // [R6]
		else $error("linear ramp step scaled");
	a_vacc_bound: assert property (tick_ff && v_acc |=> freq_ff >= $past(ramp_spd) && // [R14]
		freq_ff <= $past(spd_max) || $past(ramp_spd) > $past(spd_max))
		else $error("bus correction out of range");
	a_dn_saturate: assert property (s_tick_down |=> acc_ff >= $past(tgt_acc) && // [R22]
		acc_ff <= $past(acc_ff)) else $error("ramp undershot target");
	a_freq_plain: assert property (tick_ff && !v_acc |=> freq_ff == $past(ramp_spd)) // [R14]
		else $error("frequency differs from ramp");
	a_time_range: assert property (t_sel >= TIME_MIN_DS && t_sel <= TIME_MAX_DS) // [R2]
		else $error("ramp time out of range");
	a_level_range: assert property (dc_level >= DC_MIN_V && dc_level <= DC_MAX_V) // [R15]
		else $error("regulation level out of range");
	a_cur_status: assert property (c_hold || c_dec |=> current_limit_active_o) // [R17]
		else $error("current limit not reported");
endmodule // spr_ramp
`default_nettype wire

/* File: bench/spr_far_model.sv */
/* Far-side model: speed reference source and inverter output stage.
   Assumes the bench sets the wanted levels just after each rising edge. */
`timescale 1ns/1ps
`default_nettype none
module spr_far_model import spr_pkg::*; (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [SPD_W-1:0] ref_set_i,
	input wire logic [VOLT_W-1:0] bus_set_i,
	input wire logic [CUR_W-1:0] cur_set_i,
	output logic [SPD_W-1:0] speed_ref_o,
	output logic [VOLT_W-1:0] dc_bus_o,
	output logic [CUR_W-1:0] motor_current_o
);
	// Registered like a real sensor path, so the block sees each change one cycle late
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			speed_ref_o <= '0;
			dc_bus_o <= '0;
			motor_current_o <= '0;
		end else begin
			speed_ref_o <= ref_set_i;
			// No braking resistor in this stage, so the voltage limits stay enabled
			dc_bus_o <= bus_set_i;
			motor_current_o <= cur_set_i;
		end
	end
endmodule // spr_far_model
`default_nettype wire

/* File: bench/spr_ramp_tb.sv */
/* Self-checking bench for spr_ramp: ramp rates, source selection and limits.
   Assumes the far-side model feeds reference, bus voltage and motor current. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module spr_ramp_tb import spr_pkg::*; ;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic fdef = 1'b0, s_en = 1'b0, rq = 1'b0, dasg = 1'b0, prot = 1'b0;
	logic [2:0] src = 3'h0;
	logic [1:0] lim = 2'h0, cls = 2'h0;
	logic [SPD_W-1:0] ref_set = 16'h1388, min_spd = 16'h0000, r0, d, sref, freq, ramp;
	logic [TIME_W-1:0] at1 = 14'h0001, dt1 = 14'h0002, tm2 = 14'h0004, pt = 14'h0005;
	logic [VOLT_W-1:0] lvl = 11'h2ee, bus_set = 11'h190, bus;
	logic [CUR_W-1:0] cur_set = 11'h064, cur;
	logic [GAIN_W-1:0] gain = 10'h096;
	logic tick, alt, pact, dca, cla;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n_cyc = 0;

	always #4 clk_i = ~clk_i;

	spr_far_model far (.clk_i(clk_i), .arst_n_i(arst_n_i), .ref_set_i(ref_set),
		.bus_set_i(bus_set), .cur_set_i(cur_set), .speed_ref_o(sref), .dc_bus_o(bus),
		.motor_current_o(cur));

	// Short tick keeps a 0.1 s ramp at 100 ticks of 80 cycles
	spr_ramp #(.TICK_CYC(80)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.factory_defaults_i(fdef), .speed_ref_i(sref), .accel_time_first_i(at1),
		.decel_time_first_i(dt1), .accel_time_second_i(tm2), .decel_time_second_i(tm2),
		.protection_ramp_time_i(pt), .s_profile_enable_i(s_en),
		.second_ramp_source_sel_i(src), .digital_input_source_i(rq),
		.digital_input_assigned_i(dasg), .serial_second_ramp_i(rq),
		.fieldbus_second_ramp_i(rq), .user_prog_second_ramp_i(rq),
		.protection_ramp_req_i(prot), .min_speed_limit_i(min_spd),
		.max_speed_limit_i(16'h1388), .max_current_level_i(11'h3e8),
		.motor_current_i(cur), .limitation_type_sel_i(lim), .dc_regulation_level_i(lvl),
		.dc_regulator_gain_i(gain), .dc_bus_measured_i(bus), .supply_class_sel_i(cls),
		.freq_cmd_o(freq), .ramp_out_o(ramp), .ramp_tick_o(tick),
		.second_ramp_active_o(alt), .protection_ramp_active_o(pact),
		.dc_limit_active_o(dca), .current_limit_active_o(cla));

	task automatic complete_run();
		if (err_total == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Waits n tick pulses, then the cycle in which the ramp has moved
	task automatic tk(input int n);
		repeat (n) begin
			do begin
				@(posedge clk_i);
				#2;
			end while (tick !== 1'b1);
		end
		@(posedge clk_i);
		#2;
	endtask

	function automatic logic exp_alt(input logic [2:0] s, input logic r);
		return s == 3'h1 || (r && (s == 3'h2 || s == 3'h3 || s == 3'h5 || s == 3'h6));
	endfunction

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_i);
		`CHK("alt_rst", 1'b0, alt)
		#2 arst_n_i = 1'b1;
		do begin
			@(posedge clk_i);
			#2;
			n_cyc++;
		end while (tick !== 1'b1);
		`CHK("tick_first", 80, n_cyc)
		tk(2);
		r0 = ramp;
		tk(1);
		d = ramp - r0;
		`CHK("acc1_step", 16'h0032, d)
		tk(100);
		`CHK("acc1_end", 16'h1388, ramp)
		ref_set = 16'h07d0;
		tk(2);
		r0 = ramp;
		tk(1);
		d = r0 - ramp;
		`CHK("dec1_step", 16'h0019, d)
		tk(125);
		`CHK("dec1_end", 16'h07d0, ramp)
		bus_set = 11'h2f8;
		for (int l = 1; l < 4; l += 2) begin
			lim = l[1:0];
			tk(2);
			`CHK("vacc_freq", 16'h0dac, freq)
			`CHK("vacc_flag", 1'b1, dca)
		end
		gain = 10'h3ff;
		tk(2);
		`CHK("vacc_cap", 16'h1388, freq)
		gain = 10'h096;
		lim = 2'h0;
		ref_set = 16'h03e8;
		cur_set = 11'h3e9;
		tk(2);
		r0 = ramp;
		tk(3);
		`CHK("vhold_ramp", r0, ramp)
		`CHK("vhold_flag", 1'b1, dca)
		`CHK("vhold_freq", r0, freq)
		bus_set = 11'h190;
		cur_set = 11'h064;
		ref_set = 16'h0fa0;
		min_spd = 16'h03e8;
		tk(5);
		cur_set = 11'h3e9;
		tk(3);
		`CHK("cdec_flag", 1'b1, cla)
		r0 = ramp;
		tk(1);
		d = r0 - ramp;
		`CHK("cdec_step", 16'h000a, d)
		tk(130);
		`CHK("cdec_min", 16'h03e8, ramp)
		lim = 2'h2;
		tk(3);
		`CHK("chold_ramp", 16'h03e8, ramp)
		`CHK("chold_flag", 1'b1, cla)
		cur_set = 11'h064;
		lim = 2'h0;
		min_spd = 16'h0000;
		for (int k = 0; k < 16; k++) begin
			src = k[2:0];
			rq = k[3];
			dasg = k[3];
			repeat (6) @(posedge clk_i);
			#2;
			`CHK("alt_src", exp_alt(src, rq), alt)
		end
		src = 3'h2;
		rq = 1'b1;
		dasg = 1'b0;
		repeat (6) @(posedge clk_i);
		#2;
		`CHK("alt_unasg", 1'b0, alt)
		src = 3'h1;
		tk(2);
		r0 = ramp;
		tk(2);
		d = ramp - r0;
		`CHK("acc2_step", 16'h0019, d)
		prot = 1'b1;
		tk(1);
		`CHK("prot_flag", 1'b1, pact)
		`CHK("prot_alt", 1'b0, alt)
		tk(2);
		r0 = ramp;
		tk(1);
		d = ramp - r0;
		`CHK("prot_step", 16'h000a, d)
		prot = 1'b0;
		src = 3'h0;
		s_en = 1'b1;
		ref_set = ramp;
		tk(70);
		ref_set = 16'h0fa0;
		tk(2);
		r0 = ramp;
		tk(1);
		d = ramp - r0;
		`CHK("s_step", 1'b1, (d > 16'h0000 && d < 16'h0032))
		s_en = 1'b0;
		fdef = 1'b1;
		cls = 2'h1;
		ref_set = 16'h0000;
		bus_set = 11'h320;
		tk(2);
		`CHK("lvl_dflt_on", 1'b1, dca)
		bus_set = 11'h31f;
		tk(2);
		`CHK("lvl_dflt_off", 1'b0, dca)
		complete_run();
	end
endmodule // spr_ramp_tb
`default_nettype wire
